// file: rtl/dcf_pkg.sv
package dcf_pkg;
   localparam int DATA_W = 18;
   localparam int ADDR_W = 12;
   localparam int PTR_W = 13;
   localparam int PAY_W = 16;
   localparam int PAR_W = 9;
   localparam int THRESH_W = 12;
   localparam int CLK_PERIOD_NS = 20;
   localparam logic [2:0] WIDTH_X1 = 3'h0;
   localparam logic [2:0] WIDTH_X2 = 3'h1;
   localparam logic [2:0] WIDTH_X4 = 3'h2;
   localparam logic [2:0] WIDTH_X9 = 3'h3;
   localparam logic [2:0] WIDTH_X18 = 3'h4;
   localparam logic [2:0] SHIFT_X9 = 3'h3;
   localparam logic [2:0] SHIFT_X18 = 3'h4;
   localparam logic [PTR_W-1:0] BIT_CAPACITY = 13'h1000;
   localparam logic [ADDR_W-1:0] COUNT_RESET = 12'h000;
   localparam logic [ADDR_W-1:0] COUNT_ALL_ONES = 12'hFFF;
   localparam logic [DATA_W-1:0] READ_DATA_RESET = 18'h00000;
endpackage

// file: rtl/dcf_fifo.sv
// Summary of operation
// - width select 000..100 gives x1, x2, x4, x9, x18; 101..111 reserved.
// - port works only while its select is low; read data holds otherwise.
// - write enable defaults low-active, read enable high-active; both selectable.
// - both ports run from one common clock here.
// - pipeline low shows read data at read edge; high one edge later.
// - fifo reset clears counters, zeroes read data, sets empty flags.
// - unused upper write bits tied low; unused read bits driven low.
// - empty stop high freezes read counter while empty.
// - full stop high freezes write counter while full.
// - counters count zero to depth minus one, then wrap to zero.
// - full flag on write side, released after read pointer resync.
// - empty flag on read side, released after write pointer resync.
// - almost full when fill in bits reaches threshold or more.
// - almost empty when fill in bits is at or below threshold.
// - thresholds are 12-bit counts of data bits.
// - separate 12-bit write and read word counters, one step per transfer.
// - x9 and x18 words count as 8 and 16 bits.
// - full or empty as soon as a whole word cannot move.
`timescale 1ns/1ns
module dcf_fifo
   import dcf_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic fifo_reset_n,
   input wire logic [2:0] write_width_select,
   input wire logic [2:0] read_width_select,
   input wire logic write_port_select_n,
   input wire logic read_port_select_n,
   input wire logic write_enable,
   input wire logic read_enable,
   input wire logic write_enable_active_high,
   input wire logic read_enable_active_high,
   input wire logic read_pipeline_select,
   input wire logic empty_stop,
   input wire logic full_stop,
   input wire logic [dcf_pkg::DATA_W-1:0] write_data_bus,
   input wire logic [dcf_pkg::THRESH_W-1:0] almost_full_threshold,
   input wire logic [dcf_pkg::THRESH_W-1:0] almost_empty_threshold,
   output logic [dcf_pkg::DATA_W-1:0] read_data_bus,
   output logic full_flag,
   output logic empty_flag,
   output logic almost_full_flag,
   output logic almost_empty_flag
);
   import dcf_pkg::*;

   // payload store plus extra ninth bits
   logic mem [0:BIT_CAPACITY-1];
   logic par [0:PAR_W*64-1];

   logic [ADDR_W-1:0] write_address_counter;
   logic [ADDR_W-1:0] read_address_counter;
   logic write_lap;
   logic read_lap;
   logic [PTR_W-1:0] write_gray;
   logic [PTR_W-1:0] read_gray;
   logic [PTR_W-1:0] write_gray_meta;
   logic [PTR_W-1:0] write_gray_sync;
   logic [PTR_W-1:0] read_gray_meta;
   logic [PTR_W-1:0] read_gray_sync;
   logic [DATA_W-1:0] read_stage;

   function automatic logic [2:0] width_shift(input logic [2:0] sel);
      case (sel)
         WIDTH_X1: width_shift = 3'h0;
         WIDTH_X2: width_shift = 3'h1;
         WIDTH_X4: width_shift = 3'h2;
         WIDTH_X9: width_shift = 3'h3;
         WIDTH_X18: width_shift = 3'h4;
         default: width_shift = 3'h0;
      endcase
   endfunction

   function automatic logic [PTR_W-1:0] to_gray(input logic [PTR_W-1:0] b);
      to_gray = b ^ (b >> 1);
   endfunction

   function automatic logic [PTR_W-1:0] from_gray(input logic [PTR_W-1:0] g);
      logic [PTR_W-1:0] b;
      b[PTR_W-1] = g[PTR_W-1];
      for (int i = PTR_W - 2; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      from_gray = b;
   endfunction

   function automatic logic [PTR_W-1:0] bit_pointer(input logic lap,
         input logic [ADDR_W-1:0] cnt, input logic [2:0] sh);
      bit_pointer = {lap, ADDR_W'(cnt << sh)};
   endfunction

   function automatic logic [ADDR_W-1:0] last_word(input logic [2:0] sh);
      last_word = COUNT_ALL_ONES >> sh;
   endfunction

   wire rst = !reset_n || !fifo_reset_n;
   wire [2:0] wshift = width_shift(write_width_select);
   wire [2:0] rshift = width_shift(read_width_select);
   wire [PTR_W-1:0] wunit = PTR_W'(1) << wshift;
   wire [PTR_W-1:0] runit = PTR_W'(1) << rshift;

   // enable polarity
   wire wen_on = write_enable_active_high ? write_enable : !write_enable;
   wire ren_on = read_enable_active_high ? read_enable : !read_enable;
   wire wr_do = !write_port_select_n && wen_on && !(full_stop && full_flag);
   wire rd_do = !read_port_select_n && ren_on && !(empty_stop && empty_flag);

   // counter stepping with wrap at configured depth
   wire wwrap = write_address_counter >= last_word(wshift);
   wire rwrap = read_address_counter >= last_word(rshift);
   wire [ADDR_W-1:0] next_wcount = !wr_do ? write_address_counter :
      wwrap ? COUNT_RESET : ADDR_W'(write_address_counter + 1'b1);
   wire [ADDR_W-1:0] next_rcount = !rd_do ? read_address_counter :
      rwrap ? COUNT_RESET : ADDR_W'(read_address_counter + 1'b1);
   wire next_wlap = write_lap ^ (wr_do && wwrap);
   wire next_rlap = read_lap ^ (rd_do && rwrap);

   wire [PTR_W-1:0] wbit = bit_pointer(write_lap, write_address_counter, wshift);
   wire [PTR_W-1:0] rbit = bit_pointer(read_lap, read_address_counter, rshift);
   wire [PTR_W-1:0] next_wptr = bit_pointer(next_wlap, next_wcount, wshift);
   wire [PTR_W-1:0] next_rptr = bit_pointer(next_rlap, next_rcount, rshift);

   // fill levels in bits against the far pointer after resync
   wire [PTR_W-1:0] rptr_seen = from_gray(read_gray_sync);
   wire [PTR_W-1:0] wptr_seen = from_gray(write_gray_sync);
   wire [PTR_W-1:0] fill_wside = PTR_W'(next_wptr - rptr_seen);
   wire [PTR_W-1:0] fill_rside = PTR_W'(wptr_seen - next_rptr);
   wire next_full = fill_wside > PTR_W'(BIT_CAPACITY - wunit);
   wire next_empty = fill_rside < runit;
   wire next_almost_full_flag = fill_wside >= {1'b0, almost_full_threshold};
   wire next_almost_empty_flag = fill_rside <= {1'b0, almost_empty_threshold};

   // data lane mapping, x9 and x18 keep their ninth bits apart
   wire wide_w = wshift >= SHIFT_X9;
   wire [PAY_W-1:0] wpay = wide_w ? {write_data_bus[16:9], write_data_bus[7:0]} :
      write_data_bus[PAY_W-1:0];
   wire [1:0] wpar = {write_data_bus[17], write_data_bus[8]};
   wire [PAR_W-1:0] wpar_idx = wbit[ADDR_W-1:3];
   wire [PAR_W-1:0] rpar_idx = rbit[ADDR_W-1:3];
   wire [PAR_W-1:0] rpar_idx_hi = PAR_W'(rpar_idx + 1'b1);

   logic [PAY_W-1:0] rpay;
   always_comb begin
      rpay = '0;
      for (int i = 0; i < PAY_W; i++) begin
         if (PTR_W'(i) < runit) begin
            rpay[i] = mem[ADDR_W'(rbit[ADDR_W-1:0] + ADDR_W'(i))];
         end
      end
   end

   wire [DATA_W-1:0] rd_word = (rshift == SHIFT_X18) ?
      {par[rpar_idx_hi], rpay[15:8], par[rpar_idx], rpay[7:0]} :
      (rshift == SHIFT_X9) ? {9'h000, par[rpar_idx], rpay[7:0]} :
      {2'h0, rpay};

   // read data path: flow-through or one extra register
   wire [DATA_W-1:0] next_read_data = read_port_select_n ? read_data_bus :
      read_pipeline_select ? read_stage :
      rd_do ? rd_word : read_data_bus;

   always_ff @(posedge clk) begin
      if (clk_en && wr_do) begin
         for (int i = 0; i < PAY_W; i++) begin
            if (PTR_W'(i) < wunit) begin
               mem[ADDR_W'(wbit[ADDR_W-1:0] + ADDR_W'(i))] <= wpay[i];
            end
         end
         if (wide_w) begin
            par[wpar_idx] <= wpar[0];
         end
         if (wshift == SHIFT_X18) begin
            par[PAR_W'(wpar_idx + 1'b1)] <= wpar[1];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         write_address_counter <= COUNT_RESET;
         write_lap <= 1'b0;
         write_gray <= '0;
         read_gray_meta <= '0;
         read_gray_sync <= '0;
         full_flag <= 1'b0;
         almost_full_flag <= 1'b0;
      end else if (clk_en) begin
         write_address_counter <= next_wcount;
         write_lap <= next_wlap;
         write_gray <= to_gray(next_wptr);
         read_gray_meta <= read_gray;
         read_gray_sync <= read_gray_meta;
         full_flag <= next_full;
         almost_full_flag <= next_almost_full_flag;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         read_address_counter <= COUNT_RESET;
         read_lap <= 1'b0;
         read_gray <= '0;
         write_gray_meta <= '0;
         write_gray_sync <= '0;
         empty_flag <= 1'b1;
         almost_empty_flag <= 1'b1;
      end else if (clk_en) begin
         read_address_counter <= next_rcount;
         read_lap <= next_rlap;
         read_gray <= to_gray(next_rptr);
         write_gray_meta <= write_gray;
         write_gray_sync <= write_gray_meta;
         empty_flag <= next_empty;
         almost_empty_flag <= next_almost_empty_flag;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         read_stage <= READ_DATA_RESET;
         read_data_bus <= READ_DATA_RESET;
      end else if (clk_en) begin
         if (rd_do) begin
            read_stage <= rd_word;
         end
         read_data_bus <= next_read_data;
      end
   end

   // checks
   chk_reset_clears_flags: assert property (@(posedge clk) rst |=>
      (!full_flag && !almost_full_flag && empty_flag && almost_empty_flag
       && read_data_bus == READ_DATA_RESET && write_address_counter == COUNT_RESET))
      else $error("reset did not clear flags, counters or read data");

   chk_read_hold_deselect: assert property (@(posedge clk) disable iff (rst)
      read_port_select_n |=> $stable(read_data_bus))
      else $error("read data changed while read port deselected");

   chk_write_stop_full: assert property (@(posedge clk) disable iff (rst)
      (full_stop && full_flag) |=> write_address_counter == $past(write_address_counter))
      else $error("write counter moved while full and stopped");

   chk_read_stop_empty: assert property (@(posedge clk) disable iff (rst)
      (empty_stop && empty_flag) |=> read_address_counter == $past(read_address_counter))
      else $error("read counter moved while empty and stopped");

   chk_write_count_step: assert property (@(posedge clk) disable iff (rst)
      (clk_en && wr_do && !wwrap) |=>
      write_address_counter == ADDR_W'($past(write_address_counter) + 1'b1))
      else $error("write counter did not step by one");

   chk_read_count_wrap: assert property (@(posedge clk) disable iff (rst)
      (clk_en && rd_do && rwrap) |=> read_address_counter == COUNT_RESET)
      else $error("read counter did not wrap to zero");

   chk_empty_release_delay: assert property (@(posedge clk) disable iff (rst)
      (clk_en && empty_flag && wr_do && !rd_do && $stable(write_address_counter))
      ##0 (clk_en [*3]) |=> empty_flag)
      else $error("empty released before pointer resync");

   chk_full_release_delay: assert property (@(posedge clk) disable iff (rst)
      (clk_en && full_flag && !wr_do) ##1 (clk_en && !wr_do && $changed(read_address_counter))
      |=> full_flag)
      else $error("full released before pointer resync");

   chk_flow_through_data: assert property (@(posedge clk) disable iff (rst)
      (clk_en && rd_do && !read_pipeline_select) |=> read_data_bus == $past(rd_word))
      else $error("flow-through read data not shown at read edge");

   chk_pipelined_data: assert property (@(posedge clk) disable iff (rst)
      (clk_en && rd_do && read_pipeline_select) ##1
      (clk_en && read_pipeline_select && !read_port_select_n)
      |=> read_data_bus == $past(rd_word, 2))
      else $error("pipelined read data not one edge later");

   chk_freeze_write_count: assert property (@(posedge clk) disable iff (rst)
      !clk_en |=> $stable(write_address_counter))
      else $error("write counter moved while clock enable low");

   chk_freeze_read_count: assert property (@(posedge clk) disable iff (rst)
      !clk_en |=> $stable(read_address_counter))
      else $error("read counter moved while clock enable low");

   chk_freeze_read_data: assert property (@(posedge clk) disable iff (rst)
      !clk_en |=> $stable(read_data_bus))
      else $error("read data changed while clock enable low");

   chk_freeze_flags: assert property (@(posedge clk) disable iff (rst)
      !clk_en |=> $stable({full_flag, empty_flag, almost_full_flag, almost_empty_flag}))
      else $error("flags changed while clock enable low");

   chk_read_count_step: assert property (@(posedge clk) disable iff (rst)
      (clk_en && rd_do && !rwrap) |=>
      read_address_counter == ADDR_W'($past(read_address_counter) + 1'b1))
      else $error("read counter did not step by one");

   chk_write_count_wrap: assert property (@(posedge clk) disable iff (rst)
      (clk_en && wr_do && wwrap) |=> write_address_counter == COUNT_RESET)
      else $error("write counter did not wrap to zero");

   chk_write_idle_hold: assert property (@(posedge clk) disable iff (rst)
      (clk_en && !wr_do) |=> $stable(write_address_counter))
      else $error("write counter moved without a write");

   chk_read_idle_hold: assert property (@(posedge clk) disable iff (rst)
      (clk_en && !rd_do) |=> $stable(read_address_counter))
      else $error("read counter moved without a read");

   chk_reset_read_count: assert property (@(posedge clk) rst |=>
      read_address_counter == COUNT_RESET)
      else $error("reset did not clear read counter");

   chk_reset_laps: assert property (@(posedge clk) rst |=>
      (!write_lap && !read_lap))
      else $error("reset did not clear lap bits");

   chk_write_deselect_hold: assert property (@(posedge clk) disable iff (rst)
      write_port_select_n |=> $stable(write_address_counter))
      else $error("write counter moved while write port deselected");

   chk_read_deselect_count: assert property (@(posedge clk) disable iff (rst)
      read_port_select_n |=> $stable(read_address_counter))
      else $error("read counter moved while read port deselected");

   chk_write_lap_toggle: assert property (@(posedge clk) disable iff (rst)
      (clk_en && wr_do && wwrap) |=> write_lap != $past(write_lap))
      else $error("write lap did not toggle on wrap");

   chk_read_lap_toggle: assert property (@(posedge clk) disable iff (rst)
      (clk_en && rd_do && rwrap) |=> read_lap != $past(read_lap))
      else $error("read lap did not toggle on wrap");

   chk_reserved_width: assert property (@(posedge clk)
      (write_width_select > WIDTH_X18) |-> wunit == 13'h0001)
      else $error("reserved width code not treated as one bit");

   chk_x18_write_unit: assert property (@(posedge clk)
      (write_width_select == WIDTH_X18) |-> wunit == 13'h0010)
      else $error("x18 write word not counted as sixteen bits");

   chk_x9_read_unit: assert property (@(posedge clk)
      (read_width_select == WIDTH_X9) |-> runit == 13'h0008)
      else $error("x9 read word not counted as eight bits");

   chk_flow_hold_idle: assert property (@(posedge clk) disable iff (rst)
      (clk_en && !rd_do && !read_pipeline_select) |=> $stable(read_data_bus))
      else $error("flow-through read data changed without a read");

   chk_write_enable_level: assert property (@(posedge clk) disable iff (rst)
      (!write_port_select_n && !full_stop && write_enable == write_enable_active_high)
      |-> wr_do)
      else $error("active write enable did not start a write");

   chk_read_enable_level: assert property (@(posedge clk) disable iff (rst)
      (!read_port_select_n && !empty_stop && read_enable == read_enable_active_high)
      |-> rd_do)
      else $error("active read enable did not start a read");

   chk_write_enable_idle: assert property (@(posedge clk) disable iff (rst)
      (write_enable != write_enable_active_high) |-> !wr_do)
      else $error("write taken with enable inactive");

   chk_read_enable_idle: assert property (@(posedge clk) disable iff (rst)
      (read_enable != read_enable_active_high) |-> !rd_do)
      else $error("read taken with enable inactive");

   chk_read_gray_delay: assert property (@(posedge clk) disable iff (rst)
      clk_en |=> read_gray_sync == $past(read_gray_meta))
      else $error("read pointer sync stage skipped");

   chk_write_gray_delay: assert property (@(posedge clk) disable iff (rst)
      clk_en |=> write_gray_sync == $past(write_gray_meta))
      else $error("write pointer sync stage skipped");
endmodule

// file: verification/dcf_user.sv
`timescale 1ns/1ns
module dcf_user
   import dcf_pkg::*;
(
   input wire logic clk,
   input wire logic push,
   input wire logic pop,
   input wire logic wr_high,
   input wire logic rd_high,
   input wire logic [2:0] width,
   input wire logic [dcf_pkg::DATA_W-1:0] word,
   output logic write_enable,
   output logic read_enable,
   output logic [dcf_pkg::DATA_W-1:0] write_data_bus
);
   logic [DATA_W-1:0] last = 18'h00000;
   logic [DATA_W-1:0] mask;
   // width code to valid low bits, upper bits held low
   assign mask = (width == WIDTH_X18) ? 18'h3FFFF : (width == WIDTH_X9) ? 18'h001FF :
      (width == WIDTH_X4) ? 18'h0000F : (width == WIDTH_X2) ? 18'h00003 : 18'h00001;
   assign write_enable = push ~^ wr_high;
   assign read_enable = pop ~^ rd_high;
   // idle bus shows the inverse of the last word
   assign write_data_bus = (push ? word : ~last) & mask;
   always_ff @(posedge clk) begin
      last <= write_data_bus;
   end
endmodule

// file: verification/testbench.sv
`timescale 1ns/1ns
module testbench;
   import dcf_pkg::*;
   logic clk = 0, reset_n = 0, fifo_reset_n = 1, clk_en = 1;
   logic [2:0] write_width_select = WIDTH_X18, read_width_select = WIDTH_X18;
   logic write_port_select_n = 0, read_port_select_n = 0, read_pipeline_select = 0;
   logic empty_stop = 0, full_stop = 0, push = 0, pop = 0, wr_high = 0, rd_high = 1;
   logic [DATA_W-1:0] word = 18'h00000;
   logic [THRESH_W-1:0] almost_full_threshold = 12'hFFF, almost_empty_threshold = 12'h000;
   logic write_enable, read_enable, full_flag, empty_flag, almost_full_flag, almost_empty_flag;
   logic [DATA_W-1:0] write_data_bus, read_data_bus;
   int n_mismatch = 0, checks = 0;
   dcf_user partner (.clk, .push, .pop, .wr_high, .rd_high, .width(write_width_select),
      .word, .write_enable, .read_enable, .write_data_bus);
   dcf_fifo uut (.clk, .reset_n, .clk_en, .fifo_reset_n, .write_width_select,
      .read_width_select, .write_port_select_n, .read_port_select_n, .write_enable,
      .read_enable, .write_enable_active_high(wr_high), .read_enable_active_high(rd_high),
      .read_pipeline_select, .empty_stop, .full_stop, .write_data_bus, .almost_full_threshold,
      .almost_empty_threshold, .read_data_bus, .full_flag, .empty_flag, .almost_full_flag,
      .almost_empty_flag);
   initial begin
      forever #(CLK_PERIOD_NS / 2) clk = ~clk;
   end
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task xfer(input logic wr, input logic rd, input int n, input logic [17:0] base);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         push <= wr;
         pop <= rd;
         word <= base + 18'(i);
      end
      @(posedge clk);
      push <= 1'b0;
      pop <= 1'b0;
      #1;
   endtask
   task sc_flags_reset;
      check({read_data_bus, full_flag, almost_full_flag, empty_flag, almost_empty_flag}, 32'h3);
   endtask
   task sc_flow;
      xfer(1, 0, 1, 18'h2A5A5);
      tick(2);
      check(empty_flag, 1'b1);
      tick(1);
      check(empty_flag, 1'b0);
      xfer(1, 0, 1, 18'h15A5A);
      xfer(0, 1, 1, 18'h00000);
      check(read_data_bus, 18'h2A5A5);
      @(posedge clk);
      read_pipeline_select <= 1'b1;
      xfer(0, 1, 1, 18'h00000);
      check(read_data_bus, 18'h2A5A5);
      tick(1);
      check(read_data_bus, 18'h15A5A);
      @(posedge clk);
      read_pipeline_select <= 1'b0;
   endtask
   task sc_full;
      @(posedge clk);
      almost_full_threshold <= 12'hF00;
      full_stop <= 1'b1;
      xfer(1, 0, 239, 18'h01000);
      tick(3);
      check(almost_full_flag, 1'b0);
      xfer(1, 0, 1, 18'h010EF);
      tick(3);
      check({almost_full_flag, full_flag}, 2'b10);
      xfer(1, 0, 16, 18'h010F0);
      tick(3);
      check(full_flag, 1'b1);
      xfer(1, 0, 1, 18'h3FFFF);
      xfer(0, 1, 1, 18'h00000);
      check(read_data_bus, 18'h01000);
      tick(2);
      check(full_flag, 1'b1);
      tick(1);
      check(full_flag, 1'b0);
      xfer(0, 1, 255, 18'h00000);
      check(read_data_bus, 18'h010FF);
   endtask
   task sc_empty;
      @(posedge clk);
      empty_stop <= 1'b1;
      almost_empty_threshold <= 12'h010;
      tick(3);
      check(empty_flag, 1'b1);
      xfer(0, 1, 1, 18'h00000);
      xfer(1, 0, 2, 18'h0ABCD);
      tick(3);
      check({empty_flag, almost_empty_flag}, 2'b00);
      xfer(0, 1, 1, 18'h00000);
      check(read_data_bus, 18'h0ABCD);
      tick(3);
      check(almost_empty_flag, 1'b1);
      @(posedge clk);
      clk_en <= 1'b0;
      xfer(0, 1, 1, 18'h00000);
      check(read_data_bus, 18'h0ABCD);
      @(posedge clk);
      clk_en <= 1'b1;
      @(posedge clk);
      read_port_select_n <= 1'b1;
      xfer(0, 1, 1, 18'h00000);
      check(read_data_bus, 18'h0ABCD);
      @(posedge clk);
      read_port_select_n <= 1'b0;
      xfer(0, 1, 1, 18'h00000);
      check(read_data_bus, 18'h0ABCE);
   endtask
   task sc_mixed;
      @(posedge clk);
      fifo_reset_n <= 1'b0;
      write_width_select <= WIDTH_X2;
      read_width_select <= WIDTH_X4;
      wr_high <= 1'b1;
      rd_high <= 1'b0;
      write_port_select_n <= 1'b1;
      @(posedge clk);
      fifo_reset_n <= 1'b1;
      #1;
      sc_flags_reset();
      xfer(1, 0, 2, 18'h00003);
      tick(4);
      check(empty_flag, 1'b1);
      @(posedge clk);
      write_port_select_n <= 1'b0;
      xfer(1, 0, 1, 18'h00001);
      tick(4);
      check(empty_flag, 1'b1);
      xfer(1, 0, 1, 18'h00002);
      tick(4);
      check(empty_flag, 1'b0);
      xfer(0, 1, 1, 18'h00000);
      check(read_data_bus[3:0], 4'h9);
      tick(3);
      check(empty_flag, 1'b1);
   endtask
   task test_done;
      $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      #2000000;
      n_mismatch++;
      test_done();
   end
   initial begin
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      tick(1);
      sc_flags_reset();
      sc_flow();
      sc_full();
      sc_empty();
      sc_mixed();
      test_done();
   end
endmodule
